// [hw/hdp_pkg.sv]
// Package with the constants of the drive host port and unit select logic.
// Behaviour
// - Sector pulse occurs a switch-selected number of times per revolution.
// - One index pulse per revolution, about 2.5 us wide, starting sector zero.
// - Response gate rises about 300 ns after select-hold and command gate, status already stable.
// - Status may change during read or write; response gate then means compliance.
// - Servo clock near 9.67 MHz follows disk rotational speed.
// - Address-match output rises on unit-select tag with matching qualifier address.
// - Position-reached output rises when sensing enabled and heads over requested sector.
// - Seek-done output rises when a seek ends, on cylinder or in error.
// - Read clock is driven only when the optional read oscillator is fitted.
// - Every accepted command returns status on the return status lines.
// - Unselected device ignores all but unit select and withholds gated outputs.
// - On unit-select tag the device compares supplied address with its own.
// - Plug gives address 0 to 15; without plug the address is 15.
// - Address-match state enables gated transmitters and decoding of other commands.
// - Address on qualifier bits 4 to 7, bit 4 most significant.
// - Select-hold must be active for anything to be accepted.
// - Tag codes reach decode only while the command gate is asserted.
package hdp_pkg;
    localparam int CLK_PERIOD_NS = 40;
    localparam int RESP_DELAY_NS = 300;
    localparam int RESP_DELAY_CYC = (RESP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INDEX_WIDTH_NS = 2500;
    localparam int INDEX_WIDTH_CYC = INDEX_WIDTH_NS / CLK_PERIOD_NS;
    localparam int REV_US = 16667;
    localparam int TAG_W = 3;
    localparam int QUAL_W = 8;
    localparam int STAT_W = 8;
    localparam int ADDR_W = 4;
    localparam int SECLEN_W = 12;
    localparam int SECNUM_W = 8;
    localparam int NCO_W = 24;
    localparam int REV_CNT_W = 24;
    localparam logic [TAG_W-1:0] TAG_UNIT_SELECT = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_NO_PLUG = 4'hf;
    // Nominal servo clock increment: 9.67 MHz / 25 MHz scaled by 2^24.
    localparam logic [NCO_W-1:0] NCO_INC_NOM = 24'h630553;
    localparam int STAT_CAPACITY_BIT = 0;
    localparam int STAT_HEADS_BIT = 1;
    localparam int STAT_ATTN_BIT = 3;
    localparam int STAT_ADDR_LSB = 4;
    localparam int QUAL_ADDR_LSB = 4;
    localparam int SYNC_W = 1 + 1 + TAG_W + QUAL_W + ADDR_W + 1 + 1 + 1 + SECLEN_W;
endpackage

// [hw/hdp_sync.sv]
// Three-stage input synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/100ps
module hdp_sync #(
    parameter int W = 1
) (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] q_d;

    // Per bit, the output follows only when the last two stages agree.
    always_comb
    begin
        for (int i = 0; i < W; i++)
        begin
            q_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : q_o[i];
        end
    end

    // The first stage is read by the second stage and nothing else.
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            q_o <= '0;
        end
        else
        begin
            s1_q <= d_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            q_o <= q_d;
        end
    end
endmodule // hdp_sync

// [hw/hdp_port.sv]
// Controller-facing command port of the drive with unit select and discrete outputs.
`timescale 1ns/100ps
module hdp_port
    import hdp_pkg::*;
#(
    parameter int REV_CYCLES = REV_US * 1000 / CLK_PERIOD_NS,
    parameter bit READ_PLO_FITTED = 1'b1,
    parameter bit CAPACITY_LARGE = 1'b1
) (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic select_hold_i,
    input wire logic cmd_gate_i,
    input wire logic [TAG_W-1:0] tag_i,
    input wire logic [QUAL_W-1:0] qual_i,
    input wire logic plug_fitted_i,
    input wire logic [ADDR_W-1:0] plug_addr_i,
    input wire logic servo_index_i,
    input wire logic read_data_clk_i,
    input wire logic [SECLEN_W-1:0] sector_len_sw_i,
    input wire logic [STAT_W-1:0] drive_status_i,
    input wire logic attention_i,
    input wire logic seek_start_i,
    input wire logic seek_done_i,
    input wire logic rps_enable_i,
    input wire logic [SECNUM_W-1:0] rps_sector_i,
    output logic resp_gate_o,
    output logic [STAT_W-1:0] ret_status_o,
    output logic addr_match_o,
    output logic cmd_strobe_o,
    output logic [TAG_W-1:0] cmd_tag_o,
    output logic [QUAL_W-1:0] cmd_qual_o,
    output logic sector_o,
    output logic index_o,
    output logic servo_clk_o,
    output logic seek_end_o,
    output logic pos_reached_o,
    output logic read_clk_o
);
    typedef enum logic [1:0] {HDP_IDLE, HDP_DELAY, HDP_ANSWER} hdp_state_t;

    // True when a tag code asks for unit select.
    function automatic logic is_unit_select(input logic [TAG_W-1:0] t);
        return t == TAG_UNIT_SELECT;
    endfunction

    logic hold_s, gate_s, plug_fit_s, index_s, rdclk_s;
    logic [TAG_W-1:0] tag_s;
    logic [QUAL_W-1:0] qual_s;
    logic [ADDR_W-1:0] plug_s;
    logic [SECLEN_W-1:0] seclen_s;

    // The controller lines, plug, servo index, read clock and sector switch cross into the clock domain here.
    hdp_sync #(.W(SYNC_W)) u_sync (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .d_i({select_hold_i, cmd_gate_i, tag_i, qual_i, plug_addr_i, plug_fitted_i,
              servo_index_i, read_data_clk_i, sector_len_sw_i}),
        .q_o({hold_s, gate_s, tag_s, qual_s, plug_s, plug_fit_s, index_s, rdclk_s, seclen_s})
    );

    logic [ADDR_W-1:0] own_addr;
    logic [ADDR_W-1:0] sent_addr;
    logic [STAT_W-1:0] select_status;
    logic gated_in;

    // A missing plug leaves the lines meaningless, so the address falls back to 15.
    assign own_addr = plug_fit_s ? plug_s : ADDR_NO_PLUG;
    // Qualifier bit 4 is weight 8 and bit 7 weight 1, so the field is reversed.
    assign sent_addr = {qual_s[QUAL_ADDR_LSB], qual_s[QUAL_ADDR_LSB+1],
                        qual_s[QUAL_ADDR_LSB+2], qual_s[QUAL_ADDR_LSB+3]};
    // Select-hold opens the receivers; the gate passes the tag to decode.
    assign gated_in = hold_s && gate_s;

    // Status answered to unit select: capacity, head count, attention, echoed address.
    always_comb
    begin
        select_status = '0;
        select_status[STAT_CAPACITY_BIT] = CAPACITY_LARGE;
        select_status[STAT_HEADS_BIT] = 1'b1;
        select_status[STAT_ATTN_BIT] = attention_i;
        select_status[STAT_ADDR_LSB +: ADDR_W] = qual_s[QUAL_ADDR_LSB +: ADDR_W];
    end

    hdp_state_t state_q, state_d;
    logic [3:0] delay_q, delay_d;
    logic sel_q, sel_d;
    logic is_sel_q, is_sel_d;
    logic strobe_d;
    logic [TAG_W-1:0] ctag_d;
    logic [QUAL_W-1:0] cqual_d;
    logic [STAT_W-1:0] status_d;

    // Command handshake and selection state.
    always_comb
    begin
        state_d = state_q;
        delay_d = delay_q;
        sel_d = sel_q;
        is_sel_d = is_sel_q;
        strobe_d = 1'b0;
        ctag_d = cmd_tag_o;
        cqual_d = cmd_qual_o;
        if (!hold_s)
        begin
            // Open cable or release: drop selection and abandon any command.
            sel_d = 1'b0;
            state_d = HDP_IDLE;
        end
        else
        begin
            unique case (state_q)
                HDP_IDLE:
                begin
                    // Unselected, only unit select gets through to decode.
                    if (gated_in && (is_unit_select(tag_s) || sel_q))
                    begin
                        is_sel_d = is_unit_select(tag_s);
                        if (is_unit_select(tag_s))
                        begin
                            sel_d = (sent_addr == own_addr);
                        end
                        else
                        begin
                            strobe_d = 1'b1;
                            ctag_d = tag_s;
                            cqual_d = qual_s;
                        end
                        delay_d = 4'(RESP_DELAY_CYC - 1);
                        state_d = HDP_DELAY;
                    end
                end
                HDP_DELAY:
                begin
                    if (!gate_s)
                    begin
                        state_d = HDP_IDLE;
                    end
                    else if (delay_q == 4'h0)
                    begin
                        state_d = HDP_ANSWER;
                    end
                    else
                    begin
                        delay_d = delay_q - 4'h1;
                    end
                end
                HDP_ANSWER:
                begin
                    if (!gate_s)
                    begin
                        state_d = HDP_IDLE;
                    end
                end
            endcase
        end
        // Status is driven from acceptance on, ahead of the response gate.
        if (state_d == HDP_IDLE)
        begin
            status_d = '0;
        end
        else if (is_sel_d)
        begin
            status_d = select_status;
        end
        else
        begin
            status_d = drive_status_i;
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state_q <= HDP_IDLE;
            delay_q <= 4'h0;
            sel_q <= 1'b0;
            is_sel_q <= 1'b0;
            cmd_strobe_o <= 1'b0;
            cmd_tag_o <= '0;
            cmd_qual_o <= '0;
            ret_status_o <= '0;
            resp_gate_o <= 1'b0;
            addr_match_o <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            delay_q <= delay_d;
            sel_q <= sel_d;
            is_sel_q <= is_sel_d;
            cmd_strobe_o <= strobe_d;
            cmd_tag_o <= ctag_d;
            cmd_qual_o <= cqual_d;
            ret_status_o <= status_d;
            resp_gate_o <= (state_d == HDP_ANSWER);
            addr_match_o <= sel_d;
        end
    end

    logic [NCO_W-1:0] acc_q, acc_d, inc_q, inc_d;
    logic tick;
    logic [REV_CNT_W-1:0] rev_q, rev_d;
    logic [SECLEN_W-1:0] seclen_cnt_q, seclen_cnt_d;
    logic [SECNUM_W-1:0] secnum_q, secnum_d;
    logic [5:0] idx_q, idx_d;
    logic index_prev_q;
    logic index_edge;
    logic sector_d;

    assign index_edge = index_s && !index_prev_q;

    // Servo clock, sector and index timing follow the servo index marks.
    always_comb
    begin
        {tick, acc_d} = {1'b0, acc_q} + {1'b0, inc_q};
        inc_d = inc_q;
        rev_d = rev_q + 1'b1;
        seclen_cnt_d = seclen_cnt_q;
        secnum_d = secnum_q;
        sector_d = 1'b0;
        idx_d = (idx_q != 6'h0) ? idx_q - 6'h1 : 6'h0;
        if (index_edge)
        begin
            // A long revolution means a slow disk, so the servo clock slows too.
            if (rev_q > REV_CNT_W'(REV_CYCLES))
            begin
                inc_d = inc_q - 1'b1;
            end
            else if (rev_q < REV_CNT_W'(REV_CYCLES))
            begin
                inc_d = inc_q + 1'b1;
            end
            rev_d = '0;
            idx_d = 6'(INDEX_WIDTH_CYC);
            seclen_cnt_d = '0;
            secnum_d = '0;
            sector_d = 1'b1;
        end
        else if (tick && seclen_s != '0)
        begin
            // A zero switch setting disables sector marks between indexes.
            if (seclen_cnt_q >= seclen_s - 1'b1)
            begin
                seclen_cnt_d = '0;
                secnum_d = secnum_q + 1'b1;
                sector_d = 1'b1;
            end
            else
            begin
                seclen_cnt_d = seclen_cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            acc_q <= '0;
            inc_q <= NCO_INC_NOM;
            rev_q <= '0;
            seclen_cnt_q <= '0;
            secnum_q <= '0;
            idx_q <= 6'h0;
            index_prev_q <= 1'b0;
            sector_o <= 1'b0;
            index_o <= 1'b0;
            servo_clk_o <= 1'b0;
        end
        else
        begin
            acc_q <= acc_d;
            inc_q <= inc_d;
            rev_q <= rev_d;
            seclen_cnt_q <= seclen_cnt_d;
            secnum_q <= secnum_d;
            idx_q <= idx_d;
            index_prev_q <= index_s;
            sector_o <= sector_d;
            index_o <= (idx_d != 6'h0);
            servo_clk_o <= acc_d[NCO_W-1];
        end
    end

    logic seek_end_q, seek_end_d;

    // Seek completion is held until the next seek starts; a finish in that cycle wins.
    always_comb
    begin
        seek_end_d = seek_end_q;
        if (seek_start_i)
        begin
            seek_end_d = 1'b0;
        end
        if (seek_done_i)
        begin
            seek_end_d = 1'b1;
        end
    end

    // Seek end and position reached stay quiet until the unit is selected; the read clock is not gated.
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            seek_end_q <= 1'b0;
            seek_end_o <= 1'b0;
            pos_reached_o <= 1'b0;
            read_clk_o <= 1'b0;
        end
        else
        begin
            seek_end_q <= seek_end_d;
            seek_end_o <= seek_end_d && sel_d;
            pos_reached_o <= rps_enable_i && sel_d && (secnum_d == rps_sector_i);
            read_clk_o <= READ_PLO_FITTED && rdclk_s;
        end
    end
endmodule // hdp_port

// [tb/hdp_port_props.sv]
// Checker with the command timing, selection and index properties of the drive host port.
`timescale 1ns/100ps
module hdp_port_props
    import hdp_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic select_hold_i,
    input wire logic cmd_gate_i,
    input wire logic [TAG_W-1:0] tag_i,
    input wire logic [QUAL_W-1:0] qual_i,
    input wire logic plug_fitted_i,
    input wire logic [ADDR_W-1:0] plug_addr_i,
    input wire logic resp_gate_o,
    input wire logic [STAT_W-1:0] ret_status_o,
    input wire logic addr_match_o,
    input wire logic cmd_strobe_o,
    input wire logic [TAG_W-1:0] cmd_tag_o,
    input wire logic [QUAL_W-1:0] cmd_qual_o,
    input wire logic index_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    logic [ADDR_W-1:0] qual_addr, own_addr;
    logic [7:0] idx_len_q, idx_len_d;
    // The address goes most significant first on qualifier bit 4; a missing plug reads as 15.
    assign qual_addr = {qual_i[4], qual_i[5], qual_i[6], qual_i[7]};
    assign own_addr = plug_fitted_i ? plug_addr_i : 4'hf;
    // Counts the cycles the index output has stood high, so its width needs no long repetition.
    always_comb idx_len_d = index_o ? idx_len_q + 8'h01 : 8'h00;
    always_ff @(posedge sys_clk_i or negedge nrst_i)
        if (!nrst_i) idx_len_q <= 8'h00;
        else idx_len_q <= idx_len_d;
    // A new selection needs a matching address, then the answer follows after the delay.
    sequence s_select_answer;
        qual_addr == own_addr ##8 $rose(resp_gate_o);
    endsequence
    a_resp_needs_gate: assert property ($rose(resp_gate_o) |-> cmd_gate_i && select_hold_i)
        else $error("response gate rose without gate and hold");
    a_resp_delay_bound: assert property (
        $rose(cmd_gate_i) && select_hold_i && tag_i == TAG_UNIT_SELECT |-> ##[10:14] resp_gate_o)
        else $error("select answer missing in time");
    a_select_status: assert property (
        $rose(resp_gate_o) && tag_i == TAG_UNIT_SELECT |->
        ret_status_o[7:4] == qual_i[7:4] && ret_status_o[STAT_HEADS_BIT] && $stable(ret_status_o))
        else $error("select status wrong or moving");
    a_unsel_quiet: assert property ($rose(resp_gate_o) |-> tag_i == TAG_UNIT_SELECT || addr_match_o)
        else $error("unselected drive answered");
    a_strobe_cmd: assert property (cmd_strobe_o |-> addr_match_o && cmd_tag_o == tag_i &&
        cmd_qual_o == qual_i && cmd_tag_o != TAG_UNIT_SELECT)
        else $error("command strobe without selection");
    a_match_addr: assert property ($rose(addr_match_o) |-> s_select_answer)
        else $error("selected on wrong address");
    a_hold_drop: assert property ($fell(select_hold_i) |-> ##[1:6] !addr_match_o && !resp_gate_o)
        else $error("selection kept after hold loss");
    a_index_width: assert property ($fell(index_o) |-> idx_len_q == INDEX_WIDTH_CYC)
        else $error("index width wrong");
endmodule // hdp_port_props

bind hdp_port hdp_port_props hdp_port_props_i (.sys_clk_i, .nrst_i, .select_hold_i, .cmd_gate_i, .tag_i,
    .qual_i, .plug_fitted_i, .plug_addr_i, .resp_gate_o, .ret_status_o, .addr_match_o, .cmd_strobe_o,
    .cmd_tag_o, .cmd_qual_o, .index_o);

// [tb/hdp_ctl_model.sv]
// Disk controller model that drives select-hold, command gate, tag and qualifier lines.
`timescale 1ns/100ps
module hdp_ctl_model
    import hdp_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic resp_gate_i,
    input wire logic [STAT_W-1:0] ret_status_i,
    output logic select_hold_o = 1'b0,
    output logic cmd_gate_o = 1'b0,
    output logic [TAG_W-1:0] tag_o = 3'h0,
    output logic [QUAL_W-1:0] qual_o = 8'h00
);
    // Select-hold doubles as cable presence and only changes between commands.
    task automatic set_hold(input logic v);
        @(negedge sys_clk_i);
        select_hold_o = v;
    endtask

    // One command; dwell stretches the gate after the answer, abort withdraws it before any answer.
    task automatic issue(input logic [TAG_W-1:0] tg, input logic [QUAL_W-1:0] ql, input int dwell,
        input bit abort, output bit got, output logic [STAT_W-1:0] st);
        int n;
        got = 1'b0;
        st = 8'h00;
        @(negedge sys_clk_i);
        tag_o = tg;
        qual_o = ql;
        cmd_gate_o = 1'b1;
        for (n = 0; n < (abort ? 6 : 30) && !got; n++)
        begin
            @(posedge sys_clk_i);
            got = resp_gate_i;
            st = ret_status_i;
        end
        // An aborted command drops its gate at once; a dwell of 3 or more cycles would let the answer arrive first.
        repeat (abort ? 0 : dwell) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        // Released lines show the inverse, so a stale value cannot pass for a held one.
        cmd_gate_o = 1'b0;
        tag_o = ~tg;
        qual_o = ~ql;
        for (n = 0; n < 20; n++)
        begin
            @(posedge sys_clk_i);
            got = got | (abort & resp_gate_i);
        end
    endtask
endmodule // hdp_ctl_model

// [tb/hdp_port_tb.sv]
// Self-checking testbench of the drive host port with a controller model and a bench model.
`timescale 1ns/100ps
module hdp_port_tb;
    import hdp_pkg::*;
    logic sys_clk_i = 1'b0, nrst_i = 1'b0, plug_fitted_i = 1'b0, servo_index_i = 1'b0, read_data_clk_i = 1'b0;
    logic attention_i = 1'b0, seek_start_i = 1'b0, seek_done_i = 1'b0, rps_enable_i = 1'b0, sel_m = 1'b0;
    logic select_hold_i, cmd_gate_i, resp_gate_o, addr_match_o, cmd_strobe_o, sector_o, index_o;
    logic servo_clk_o, seek_end_o, pos_reached_o, read_clk_o, sp, rp;
    logic [TAG_W-1:0] tag_i, cmd_tag_o, st_tag;
    logic [QUAL_W-1:0] qual_i, cmd_qual_o, st_qual, q;
    logic [STAT_W-1:0] ret_status_o, stat, drive_status_i = 8'h00;
    logic [ADDR_W-1:0] plug_addr_i = 4'h0;
    logic [SECLEN_W-1:0] sector_len_sw_i = 12'h064;
    logic [SECNUM_W-1:0] rps_sector_i = 8'h00;
    bit got;
    int fails = 0, n_compared = 0, n_sec = 0, n_servo = 0, n_idx = 0, n_cyc = 0, n_rdclk = 0, k, t;

    hdp_port #(.REV_CYCLES(2000)) hdp_port_i (.sys_clk_i, .nrst_i, .select_hold_i, .cmd_gate_i, .tag_i,
        .qual_i, .plug_fitted_i, .plug_addr_i, .servo_index_i, .read_data_clk_i, .sector_len_sw_i,
        .drive_status_i, .attention_i, .seek_start_i, .seek_done_i, .rps_enable_i, .rps_sector_i,
        .resp_gate_o, .ret_status_o, .addr_match_o, .cmd_strobe_o, .cmd_tag_o, .cmd_qual_o, .sector_o,
        .index_o, .servo_clk_o, .seek_end_o, .pos_reached_o, .read_clk_o);
    hdp_ctl_model hdp_ctl_model_i (.sys_clk_i, .resp_gate_i(resp_gate_o), .ret_status_i(ret_status_o),
        .select_hold_o(select_hold_i), .cmd_gate_o(cmd_gate_i), .tag_o(tag_i), .qual_o(qual_i));

    // Clock, and a raw read oscillator at a quarter of its rate; one changing every cycle would never pass the agree filter.
    always #20 sys_clk_i = ~sys_clk_i;
    always #80 read_data_clk_i = ~read_data_clk_i;
    // Records strobed commands and counts sector, index and servo clock activity.
    always @(posedge sys_clk_i)
    begin
        if (cmd_strobe_o === 1'b1)
        begin
            st_tag = cmd_tag_o;
            st_qual = cmd_qual_o;
        end
        n_sec += (sector_o === 1'b1);
        n_idx += (index_o === 1'b1);
        n_servo += (servo_clk_o === 1'b1 && sp === 1'b0);
        sp = servo_clk_o;
        n_rdclk += (read_clk_o === 1'b1 && rp === 1'b0);
        rp = read_clk_o;
        n_cyc++;
    end

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_in(input string n, input int lo, input int hi, input int g);
        n_compared++;
        if (g < lo || g > hi)
        begin
            fails++;
            $display("mismatch %s expected %0d to %0d seen %0d", n, lo, hi, g);
        end
    endtask

    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Sends one command and checks it against the bench model of selection and status.
    task automatic cmd(input logic [TAG_W-1:0] tg, input logic [QUAL_W-1:0] ql, input bit ab);
        logic ex_resp;
        logic [STAT_W-1:0] ex;
        ex_resp = !ab && (tg == 3'h0 || sel_m);
        ex = drive_status_i;
        st_tag = ~tg;
        st_qual = ~ql;
        if (tg == 3'h0)
        begin
            sel_m = {ql[4], ql[5], ql[6], ql[7]} == (plug_fitted_i ? plug_addr_i : 4'hf);
            ex = {ql[7:4], attention_i, 3'h3};
        end
        hdp_ctl_model_i.issue(tg, ql, $urandom_range(3, 0), ab, got, stat);
        chk("response", ex_resp, got);
        if (ex_resp)
            chk("status", ex, stat);
        chk("match", sel_m, addr_match_o);
        if (ex_resp && tg != 3'h0)
        begin
            chk("tag", tg, st_tag);
            chk("qual", ql, st_qual);
        end
    endtask

    initial
    begin
        void'($urandom(96246));
        repeat (6) @(posedge sys_clk_i);
        @(negedge sys_clk_i) nrst_i = 1'b1;
        hdp_ctl_model_i.set_hold(1'b1);
        repeat (6) @(posedge sys_clk_i);
        // Unselected: tag 1 is ignored; without a plug 14 misses and 15 selects.
        cmd(3'h1, 8'hff, 1'b0);
        cmd(3'h0, 8'h70, 1'b0);
        cmd(3'h0, 8'hf5, 1'b0);
        // Plugged addresses, zero first, with random and matching qualifiers in turn.
        for (k = 0; k < 12; k++)
        begin
            @(negedge sys_clk_i);
            plug_fitted_i = 1'b1;
            plug_addr_i = (k < 2) ? 4'h0 : 4'($urandom);
            attention_i = 1'($urandom);
            q = 8'($urandom);
            if (k[0])
                q[7:4] = {plug_addr_i[0], plug_addr_i[1], plug_addr_i[2], plug_addr_i[3]};
            repeat (6) @(posedge sys_clk_i);
            cmd(3'h0, q, 1'b0);
        end
        // Selected: every other tag is decoded and answered with live status, then one abort.
        for (k = 1; k < 8; k++)
        begin
            @(negedge sys_clk_i) drive_status_i = 8'($urandom);
            cmd(k[2:0], 8'($urandom), 1'b0);
        end
        cmd(3'h2, 8'h01, 1'b1);
        // Seek end is set by the done pulse and cleared again by the next start.
        @(negedge sys_clk_i) seek_done_i = 1'b1;
        @(negedge sys_clk_i) seek_done_i = 1'b0;
        repeat (3) @(negedge sys_clk_i);
        chk("seek end", 8'h01, seek_end_o);
        seek_start_i = 1'b1;
        @(negedge sys_clk_i) seek_start_i = 1'b0;
        repeat (3) @(negedge sys_clk_i);
        chk("seek end", 8'h00, seek_end_o);
        // One index with sector zero requested; activity is counted over 993 cycles.
        rps_enable_i = 1'b1;
        servo_index_i = 1'b1;
        n_sec = 0;
        n_servo = 0;
        n_idx = 0;
        n_cyc = 0;
        n_rdclk = 0;
        for (t = 0; t < 12 && pos_reached_o !== 1'b1; t++)
            @(negedge sys_clk_i);
        chk("pos reached", 8'h01, pos_reached_o);
        servo_index_i = 1'b0;
        repeat (988) @(negedge sys_clk_i);
        chk_in("index width", 62, 62, n_idx);
        // A 9.67 MHz clock seen from 25 MHz gives 967 rising edges per 2500 cycles.
        chk_in("servo edges", n_cyc * 967 / 2500 - 2, n_cyc * 967 / 2500 + 2, n_servo);
        chk_in("read clock", n_cyc / 4 - 1, n_cyc / 4 + 1, n_rdclk);
        chk_in("sectors", n_servo / 100, n_servo / 100 + 2, n_sec);
        // Cable loss drops selection, and afterwards a non-select tag is ignored.
        hdp_ctl_model_i.set_hold(1'b0);
        repeat (8) @(posedge sys_clk_i);
        sel_m = 1'b0;
        chk("match", 8'h00, addr_match_o);
        hdp_ctl_model_i.set_hold(1'b1);
        repeat (6) @(posedge sys_clk_i);
        cmd(3'h3, 8'h00, 1'b0);
        wrap_up();
    end
endmodule // hdp_port_tb
